// file: core/pfc_pkg.sv
// constants shared by the flash program/erase controller files
// assumes a 32-bit classic wishbone slave and a 40 MHz system clock
package pfc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADR_TARGET = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_INTR = 8'h24;
  localparam logic [7:0] ADR_STAGING_WORD_0 = 8'h30;
  localparam logic [7:0] ADR_STAGING_WORD_1 = 8'h34;
  localparam logic [7:0] ADR_STAGING_WORD_2 = 8'h38;
  localparam logic [7:0] ADR_STAGING_WORD_3 = 8'h3c;

  ////////////////////////////////////////////////////////////////////////
  // command register fields
  localparam int CMD_WRITE = 0;
  localparam int CMD_MASS = 1;
  localparam int CMD_PAGE = 2;
  localparam int WIDTH_BIT = 4;
  localparam int ERASE_LSB = 8;
  localparam int BUSY_BIT = 24;
  localparam int UNLOCK_LSB = 28;
  localparam logic [3:0] UNLOCK_KEY = 4'h2;
  localparam logic [7:0] ERASE_PAGE_CODE = 8'h55;
  localparam logic [7:0] ERASE_MASS_CODE = 8'haa;

  ////////////////////////////////////////////////////////////////////////
  // interrupt register fields
  localparam int FLAG_DONE = 0;
  localparam int FLAG_DENIED = 1;
  localparam int IE_DONE = 8;
  localparam int IE_DENIED = 9;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // timing: system clock and flash clock rates
  localparam int CLK_HZ = 40_000_000;
  localparam int FLASH_HZ = 1_000_000;
  localparam int FLASH_DIV = CLK_HZ / FLASH_HZ;

  typedef enum logic [1:0] {
    OP_WRITE,
    OP_PAGE,
    OP_MASS
  } pfc_op_type;

endpackage

// file: core/pfc_op_if.sv
// carrier between command logic and the flash operation engine
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface pfc_op_if;
  logic start;
  pfc_pkg::pfc_op_type op;
  logic [31:0] addr;
  logic [127:0] data;
  logic wide;
  logic busy;
  logic done;

  modport ctl (output start, output op, output addr, output data,
    output wide, input busy, input done);
  modport eng (input start, input op, input addr, input data,
    input wide, output busy, output done);
endinterface

// file: core/pfc_engine.sv
// flash operation engine: paces requests to the array on the flash tick
// assumes the array holds ack high for one cycle per accepted request
`timescale 1ns/100ps
module pfc_engine #(
  parameter int DIV = pfc_pkg::FLASH_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  pfc_op_if.eng op,
  output logic fl_req_o,
  output pfc_pkg::pfc_op_type fl_op_o,
  output logic [31:0] fl_addr_o,
  output logic [127:0] fl_data_o,
  output logic fl_wide_o,
  input wire logic fl_ack_i
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_TICK,
    ST_REQ
  } pfc_eng_state_type;

  // worst case: start lands just after a tick, so a full period plus one
  localparam int TICK_MAX = DIV + 1;

  pfc_eng_state_type state_q;
  logic [7:0] div_q;
  logic tick_q;
  logic done_q;

  ////////////////////////////////////////////////////////////////////////
  // flash clock enable: the array only accepts requests on this tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q == 8'(DIV - 1)) begin
      div_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      fl_req_o <= 1'b0;
      fl_op_o <= pfc_pkg::OP_WRITE;
      fl_addr_o <= pfc_pkg::RESET_WORD;
      fl_data_o <= '0;
      fl_wide_o <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (op.start) begin
            fl_op_o <= op.op;
            fl_addr_o <= op.addr;
            fl_data_o <= op.data;
            fl_wide_o <= op.wide;
            state_q <= ST_WAIT_TICK;
          end
        end
        ST_WAIT_TICK: begin
          if (tick_q) begin
            fl_req_o <= 1'b1;
            state_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (fl_ack_i) begin
            fl_req_o <= 1'b0;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          fl_req_o <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign op.busy = (state_q != ST_IDLE);
  assign op.done = done_q;

  ////////////////////////////////////////////////////////////////////////
  sequence s_started;
    op.start && state_q == ST_IDLE;
  endsequence

  a_req_paced: assert property (@(posedge clk_i) disable iff (rst_i)
    s_started |=> ##[0:TICK_MAX] fl_req_o)
    else $error("array request not issued after start");

  a_req_held: assert property (@(posedge clk_i) disable iff (rst_i)
    fl_req_o && !fl_ack_i |=> fl_req_o && $stable(fl_addr_o))
    else $error("array request dropped before ack");

endmodule

// file: core/pfc_ctrl.sv
// flash program/erase controller: wishbone registers and command logic
// assumes a classic wishbone master and an array behind pfc_engine
`timescale 1ns/100ps
// Notes on behaviour
// - writing 1 to page-wipe starts erasing the page at target location
// - page-wipe bit clears itself when the page erase finishes
// - page-wipe bit reads 1 while erasing, 0 otherwise
// - software writes of 0 to command bits are ignored
// - writing 1 to full-wipe erases the whole array; 0 does nothing
// - full-wipe bit clears itself when the whole-array erase ends
// - writing 1 to bit 0 programs staged data at target location
// - word-write bit reads 1 while a program is pending or running
// - interrupt register bit 9 enables the denied interrupt
// - interrupt register bit 8 enables the finish interrupt
// - denied flag, bit 1, sets on a write attempt while busy or locked
// - denied flag: software writing 1 does nothing, writing 0 clears
// - finish flag, bit 0, sets when any operation completes; 0 clears
// - four staging words form the 128-bit program word, low word first
// - key 0x2 in the top nibble unlocks; any other value locks
// - while busy, writes to all but the interrupt register are ignored
// - width bit 0 programs 128 bits, 1 programs only the first word
// - erase needs selector 0x55 page or 0xaa mass; cleared on finish
module pfc_ctrl #(
  parameter int DIV = pfc_pkg::FLASH_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic fl_req_o,
  output pfc_pkg::pfc_op_type fl_op_o,
  output logic [31:0] fl_addr_o,
  output logic [127:0] fl_data_o,
  output logic fl_wide_o,
  input wire logic fl_ack_i
);

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  pfc_op_if op ();

  logic [31:0] target_q;
  logic [3:0] unlock_q;
  logic [7:0] erase_q;
  logic wide_q;
  logic [2:0] cmd_q;
  logic [1:0] flags_q;
  logic [1:0] ie_q;
  logic [31:0] stage_q [4];
  logic start_q;
  pfc_pkg::pfc_op_type op_q;

  logic access;
  logic wr;
  logic busy;
  logic ctrl_wr;
  logic [31:0] ctrl_new;
  logic [2:0] cmd_req;
  logic any_req;
  logic req_ok;
  pfc_pkg::pfc_op_type req_op;
  logic deny_set;
  logic [1:0] flag_clr;

  ////////////////////////////////////////////////////////////////////////
  // bus decode and command checking
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = access && wb_we_i;
  assign busy = (cmd_q != 3'b000);
  assign ctrl_wr = wr && wb_adr_i == pfc_pkg::ADR_CTRL;
  assign ctrl_new = merge({unlock_q, 12'h000, erase_q, 3'b000, wide_q,
    4'h0}, wb_dat_i, wb_sel_i);
  // only ones count: a zero written to a command bit is a no-op
  assign cmd_req = (wb_sel_i[0] ? wb_dat_i[2:0] : 3'b000);
  assign any_req = ctrl_wr && cmd_req != 3'b000;

  always_comb begin
    req_op = pfc_pkg::OP_WRITE;
    req_ok = 1'b0;
    if (cmd_req[pfc_pkg::CMD_MASS]) begin
      req_op = pfc_pkg::OP_MASS;
      req_ok = ctrl_new[pfc_pkg::ERASE_LSB +: 8]
        == pfc_pkg::ERASE_MASS_CODE;
    end else if (cmd_req[pfc_pkg::CMD_PAGE]) begin
      req_op = pfc_pkg::OP_PAGE;
      req_ok = ctrl_new[pfc_pkg::ERASE_LSB +: 8]
        == pfc_pkg::ERASE_PAGE_CODE;
    end else begin
      req_ok = 1'b1;
    end
    // locked or busy: refuse; the key is the nibble after this write
    if (busy || ctrl_new[pfc_pkg::UNLOCK_LSB +: 4]
        != pfc_pkg::UNLOCK_KEY) begin
      req_ok = 1'b0;
    end
  end

  assign deny_set = any_req && !req_ok;
  assign flag_clr = (wr && wb_adr_i == pfc_pkg::ADR_INTR && wb_sel_i[0])
    ? ~wb_dat_i[1:0] : 2'b00;

  ////////////////////////////////////////////////////////////////////////
  // control fields; frozen while busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_q <= pfc_pkg::RESET_WORD;
      unlock_q <= 4'h0;
      erase_q <= 8'h00;
      wide_q <= 1'b0;
    end else begin
      if (wr && !busy && wb_adr_i == pfc_pkg::ADR_TARGET) begin
        target_q <= merge(target_q, wb_dat_i, wb_sel_i);
      end
      if (ctrl_wr && !busy) begin
        unlock_q <= ctrl_new[pfc_pkg::UNLOCK_LSB +: 4];
        erase_q <= ctrl_new[pfc_pkg::ERASE_LSB +: 8];
        wide_q <= ctrl_new[pfc_pkg::WIDTH_BIT];
      end else if (op.done && op_q != pfc_pkg::OP_WRITE) begin
        erase_q <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // staging words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        stage_q[i] <= pfc_pkg::RESET_WORD;
      end
    end else if (wr && !busy && wb_adr_i[7:4] == pfc_pkg::ADR_STAGING_WORD_0[7:4]) begin
      stage_q[wb_adr_i[3:2]] <= merge(stage_q[wb_adr_i[3:2]], wb_dat_i,
        wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command bits: set by software, cleared only by completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= 3'b000;
      start_q <= 1'b0;
      op_q <= pfc_pkg::OP_WRITE;
    end else begin
      start_q <= 1'b0;
      if (op.done) begin
        cmd_q <= 3'b000;
      end else if (any_req && req_ok) begin
        start_q <= 1'b1;
        op_q <= req_op;
        case (req_op)
          pfc_pkg::OP_MASS: cmd_q[pfc_pkg::CMD_MASS] <= 1'b1;
          pfc_pkg::OP_PAGE: cmd_q[pfc_pkg::CMD_PAGE] <= 1'b1;
          default: cmd_q[pfc_pkg::CMD_WRITE] <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags and enables; a hardware set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= 2'b00;
      ie_q <= 2'b00;
    end else begin
      flags_q <= (flags_q & ~flag_clr)
        | {deny_set, op.done};
      if (wr && wb_adr_i == pfc_pkg::ADR_INTR && wb_sel_i[1]) begin
        ie_q <= wb_dat_i[pfc_pkg::IE_DONE +: 2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags_q & ie_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone answer: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= pfc_pkg::RESET_WORD;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= pfc_pkg::RESET_WORD;
      if (access && !wb_we_i) begin
        case (wb_adr_i)
          pfc_pkg::ADR_TARGET: wb_dat_o <= target_q;
          pfc_pkg::ADR_CTRL: wb_dat_o <= {unlock_q, 3'b000, busy, 8'h00,
            erase_q, 3'b000, wide_q, 1'b0, cmd_q};
          pfc_pkg::ADR_INTR: wb_dat_o <= {22'h0, ie_q, 6'h00, flags_q};
          pfc_pkg::ADR_STAGING_WORD_0,
          pfc_pkg::ADR_STAGING_WORD_1,
          pfc_pkg::ADR_STAGING_WORD_2,
          pfc_pkg::ADR_STAGING_WORD_3: wb_dat_o <= stage_q[wb_adr_i[3:2]];
          default: wb_dat_o <= pfc_pkg::RESET_WORD;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // engine hookup
  assign op.start = start_q;
  assign op.op = op_q;
  assign op.addr = target_q;
  assign op.wide = wide_q;
  assign op.data = {stage_q[3], stage_q[2], stage_q[1],
    stage_q[0]};

  pfc_engine #(
    .DIV(DIV)
  ) u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .op(op.eng),
    .fl_req_o(fl_req_o),
    .fl_op_o(fl_op_o),
    .fl_addr_o(fl_addr_o),
    .fl_data_o(fl_data_o),
    .fl_wide_o(fl_wide_o),
    .fl_ack_i(fl_ack_i)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_good_page;
    any_req && req_ok && req_op == pfc_pkg::OP_PAGE;
  endsequence

  sequence s_finish;
    op.done ##1 1'b1;
  endsequence

  a_page_start: assert property (@(posedge clk_i) disable iff (rst_i)
    s_good_page |=> cmd_q[pfc_pkg::CMD_PAGE] && busy)
    else $error("page erase did not start");

  a_cmd_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    busy && !op.done |=> cmd_q == $past(cmd_q))
    else $error("command bit changed before completion");

  a_finish_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    s_finish |-> cmd_q == 3'b000 && flags_q[pfc_pkg::FLAG_DONE])
    else $error("completion did not clear command and set finish");

  a_erase_sel_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    op.done && op_q != pfc_pkg::OP_WRITE |=> erase_q == 8'h00)
    else $error("erase selector not cleared on finish");

  a_denied_set: assert property (@(posedge clk_i) disable iff (rst_i)
    deny_set |=> flags_q[pfc_pkg::FLAG_DENIED]
      && !start_q)
    else $error("refused request not flagged");

  a_denied_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    flags_q[pfc_pkg::FLAG_DENIED] && !flag_clr[1]
      |=> flags_q[pfc_pkg::FLAG_DENIED])
    else $error("denied flag lost without a zero write");

  a_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags_q & ie_q) != 2'b00 |=> irq_o)
    else $error("interrupt not raised for enabled flag");

  a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags_q & ie_q) == 2'b00 |=> !irq_o)
    else $error("interrupt raised with no enabled flag");

  a_busy_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    busy |=> stage_q[0] == $past(stage_q[0])
      && target_q == $past(target_q))
    else $error("register changed while busy");

  a_busy_cover: assert property (@(posedge clk_i) disable iff (rst_i)
    op.busy |-> busy)
    else $error("engine running with no command bit set");

  a_sel_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    any_req && cmd_req == 3'b100
      && ctrl_new[pfc_pkg::ERASE_LSB +: 8] != pfc_pkg::ERASE_PAGE_CODE
      |=> !start_q && flags_q[pfc_pkg::FLAG_DENIED])
    else $error("page erase started without its selector");

endmodule

// file: tb/pfc_flash_model.sv
// behavioural flash array answering the controller's request handshake
// assumes requests are held until acked, one operation at a time
`timescale 1ns/100ps
module pfc_flash_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic fl_req_i,
  input wire pfc_pkg::pfc_op_type fl_op_i,
  input wire logic [31:0] fl_addr_i,
  input wire logic [127:0] fl_data_i,
  input wire logic fl_wide_i,
  output logic fl_ack_o
);
  logic [7:0] cnt_q;
  pfc_pkg::pfc_op_type op_q;
  logic [31:0] addr_q;
  logic [127:0] data_q;
  logic wide_q;
  int n_ops;

  ////////////////////////////////////////////////////////////////////////
  // slow mode keeps the array busy long enough to poke registers meanwhile
  always_ff @(posedge clk_i) begin
    if (rst_i || !fl_req_i || fl_ack_o) begin
      cnt_q <= 8'h00;
      fl_ack_o <= 1'b0;
    end else if (cnt_q == (slow_i ? 8'h3c : 8'h01)) begin
      fl_ack_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      n_ops <= 0;
    end else if (fl_req_i && !fl_ack_o && cnt_q == 8'h00) begin
      op_q <= fl_op_i;
      addr_q <= fl_addr_i;
      data_q <= fl_data_i;
      wide_q <= fl_wide_i;
      n_ops <= n_ops + 1;
    end
  end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the flash program/erase controller
// assumes a wishbone master here and the array model on the far side
`timescale 1ns/100ps
module tb_top;
  localparam logic [31:0] KEY = {pfc_pkg::UNLOCK_KEY, 28'h0000000};
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } pfc_row_type;
  pfc_row_type rows [7] = '{
    '{8'h30, 32'h0123_4567, 32'h0123_4567},
    '{8'h34, 32'h89ab_cdef, 32'h89ab_cdef},
    '{8'h38, 32'h0f1e_2d3c, 32'h0f1e_2d3c},
    '{8'h3c, 32'h4b5a_6978, 32'h4b5a_6978},
    '{8'h00, 32'h0000_1000, 32'h0000_1000},
    '{8'h24, 32'h0000_0303, 32'h0000_0300},
    '{8'h50, 32'hffff_ffff, 32'h0000_0000}};
  logic [7:0] adrs [7] = '{8'h00, 8'h08, 8'h24, 8'h30, 8'h34, 8'h38, 8'h3c};
  logic clk_i, rst_i, cyc, stb, we, slow, irq_o, wb_ack_o, fl_req_o;
  logic fl_wide_o, fl_ack_i;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, wb_dat_o, fl_addr_o, r;
  logic [127:0] fl_data_o;
  pfc_pkg::pfc_op_type fl_op_o;
  int fails, n_compared;

  pfc_ctrl #(.DIV(4)) i_pfc_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .fl_req_o(fl_req_o),
    .fl_op_o(fl_op_o), .fl_addr_o(fl_addr_o), .fl_data_o(fl_data_o),
    .fl_wide_o(fl_wide_o), .fl_ack_i(fl_ack_i));
  pfc_flash_model i_pfc_flash_model (.clk_i(clk_i), .rst_i(rst_i),
    .slow_i(slow), .fl_req_i(fl_req_o), .fl_op_i(fl_op_o),
    .fl_addr_i(fl_addr_o), .fl_data_i(fl_data_o), .fl_wide_i(fl_wide_o),
    .fl_ack_o(fl_ack_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // bus and check tasks
  // no limit of its own: a missing ack is caught by the watchdog
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, r & m);
  endtask
  task wait_idle;
    int k;
    k = 0;
    do begin
      xfer(8'h08, 1'b0, 32'h0);
      k++;
    end while (r[24] !== 1'b0 && k < 100);
    chk("idle", 1'b0, r[24]);
  endtask
  task end_test(input string nm);
    $display("test %s done", nm);
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #500000;
    $display("mismatch watchdog expected finish seen timeout");
    fails++;
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hf;
    slow = 1'b1;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      xfer(rows[i].a, 1'b1, rows[i].d);
      rdchk("row", rows[i].a, 32'hffff_ffff, rows[i].e);
    end
    end_test("registers");
    xfer(8'h08, 1'b1, KEY | 32'h1);
    rdchk("write pending", 8'h08, 32'h0100_0001, 32'h0100_0001);
    wait_idle;
    chk("op", pfc_pkg::OP_WRITE, i_pfc_flash_model.op_q);
    chk("addr", 32'h1000, i_pfc_flash_model.addr_q);
    chk("data", {rows[3].d, rows[2].d, rows[1].d, rows[0].d},
      i_pfc_flash_model.data_q);
    chk("wide", 1'b0, i_pfc_flash_model.wide_q);
    rdchk("flags", 8'h24, 32'h0000_0303, 32'h0000_0301);
    chk("irq done", 1'b1, irq_o);
    xfer(8'h24, 1'b1, 32'h0000_0100);
    rdchk("flag clear", 8'h24, 32'h0000_0303, 32'h0000_0100);
    chk("irq off", 1'b0, irq_o);
    end_test("program");
    slow <= 1'b0;
    xfer(8'h08, 1'b1, KEY | 32'h11);
    wait_idle;
    chk("narrow", 1'b1, i_pfc_flash_model.wide_q);
    chk("ops", 2, i_pfc_flash_model.n_ops);
    end_test("narrow");
    slow <= 1'b1;
    xfer(8'h00, 1'b1, 32'h0000_2000);
    // selector 0x55 and key loaded with the command
    xfer(8'h08, 1'b1, KEY | 32'h0000_5504);
    rdchk("erasing", 8'h08, 32'h0100_ff04, 32'h0100_5504);
    xfer(8'h08, 1'b1, KEY);
    xfer(8'h30, 1'b1, 32'hdead_beef);
    xfer(8'h24, 1'b1, 32'h0000_0200);
    rdchk("held", 8'h08, 32'h0000_0004, 32'h0000_0004);
    xfer(8'h08, 1'b1, KEY | 32'h0000_5504);
    rdchk("busy deny", 8'h24, 32'h0000_0302, 32'h0000_0202);
    chk("irq deny", 1'b1, irq_o);
    wait_idle;
    rdchk("page end", 8'h08, 32'h0000_ff07, 32'h0);
    chk("page op", pfc_pkg::OP_PAGE, i_pfc_flash_model.op_q);
    chk("page addr", 32'h2000, i_pfc_flash_model.addr_q);
    chk("ops", 3, i_pfc_flash_model.n_ops);
    rdchk("staging kept", 8'h30, 32'hffff_ffff, rows[0].d);
    xfer(8'h24, 1'b1, 32'h0000_0202);
    rdchk("deny sticky", 8'h24, 32'h0000_0003, 32'h2);
    xfer(8'h24, 1'b1, 32'h0000_0200);
    rdchk("deny clear", 8'h24, 32'h0000_0003, 32'h0);
    chk("irq idle", 1'b0, irq_o);
    end_test("page");
    xfer(8'h08, 1'b1, KEY | 32'h0000_aa04);
    rdchk("bad sel deny", 8'h24, 32'h0000_0002, 32'h2);
    rdchk("bad sel cmd", 8'h08, 32'h0100_0007, 32'h0);
    xfer(8'h24, 1'b1, 32'h0000_0200);
    end_test("selector");
    xfer(8'h08, 1'b1, KEY | 32'h0000_aa02);
    wait_idle;
    chk("mass op", pfc_pkg::OP_MASS, i_pfc_flash_model.op_q);
    rdchk("mass end", 8'h08, 32'h0000_ff07, 32'h0);
    xfer(8'h08, 1'b1, KEY);
    rdchk("no op", 8'h08, 32'h0100_0007, 32'h0);
    chk("ops", 4, i_pfc_flash_model.n_ops);
    end_test("mass");
    for (int b = 0; b < 3; b++) begin
      xfer(8'h08, 1'b1, 32'h3000_0000 | (32'h1 << b));
      rdchk("locked cmd", 8'h08, 32'h0100_0007, 32'h0);
      rdchk("locked deny", 8'h24, 32'h0000_0002, 32'h2);
      chk("irq locked", 1'b1, irq_o);
      xfer(8'h24, 1'b1, 32'h0000_0200);
    end
    chk("ops", 4, i_pfc_flash_model.n_ops);
    end_test("locked");
    xfer(8'h24, 1'b1, 32'h0000_0200);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (adrs[i]) begin
      rdchk("reset value", adrs[i], 32'hffff_ffff, pfc_pkg::RESET_WORD);
    end
    chk("irq reset", 1'b0, irq_o);
    end_test("reset");
    finish_test;
  end
endmodule
